// file: rtl/lat_pkg.sv
/*
 latency and termination timing package: band codes, lookup tables, field positions.
 assumes: used by the latency selection block and its table helper.
*/
package lat_pkg;
   localparam int BAND_W    = 3;
   localparam int LAT_W     = 6;
   localparam int NUM_BANDS = 7;
   localparam int TERM_W    = 4;

   typedef logic [BAND_W-1:0] band_t;
   typedef logic [LAT_W-1:0]  lat_t;

   // band codes, lowest to highest frequency
   localparam band_t BAND_266  = 3'h0;
   localparam band_t BAND_533  = 3'h1;
   localparam band_t BAND_800  = 3'h2;
   localparam band_t BAND_1066 = 3'h3;
   localparam band_t BAND_1333 = 3'h4;
   localparam band_t BAND_1600 = 3'h5;
   localparam band_t BAND_TOP  = 3'h6;

   // termination field positions
   localparam int TERM_MSB    = 3;
   localparam int NT_HI_BIT   = 7;
   localparam logic [TERM_W-1:0] TERM_OFF = 4'h0;

   // burst-length extension for 32-beat bursts
   localparam lat_t BL32_EXTRA = 6'h08;

   // zero marks a value that is not available in that band
   localparam lat_t LAT_NA = 6'h00;

   // set B third band is illegible; parameter default in top
   localparam lat_t WL_B_BAND2_DEFAULT = 6'h0C;

   typedef lat_t tab_t [NUM_BANDS];

   localparam tab_t RD_NODBI  = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20};
   localparam tab_t RD_DBI    = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24};
   localparam tab_t WR_SET_A  = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10};
   localparam tab_t WR_SET_B  = '{6'h04, 6'h08, 6'h00, 6'h12, 6'h16, 6'h1A, 6'h1E};
   localparam tab_t WREC      = '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22};
   localparam tab_t RTP       = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E};
   localparam tab_t TON_A     = '{6'h00, 6'h00, 6'h00, 6'h04, 6'h04, 6'h06, 6'h06};
   localparam tab_t TON_B     = '{6'h00, 6'h00, 6'h06, 6'h0C, 6'h0E, 6'h12, 6'h14};
   localparam tab_t TOFF_A    = '{6'h00, 6'h00, 6'h00, 6'h14, 6'h16, 6'h18, 6'h1A};
   localparam tab_t TOFF_B    = '{6'h00, 6'h00, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
   localparam tab_t RTON_N    = '{6'h00, 6'h00, 6'h00, 6'h0E, 6'h12, 6'h16, 6'h1A};
   localparam tab_t RTON_D    = '{6'h00, 6'h00, 6'h00, 6'h10, 6'h16, 6'h1A, 6'h1E};
   localparam tab_t RTOFF_N   = '{6'h00, 6'h00, 6'h00, 6'h20, 6'h24, 6'h2A, 6'h2E};
   localparam tab_t RTOFF_D   = '{6'h00, 6'h00, 6'h00, 6'h22, 6'h28, 6'h2E, 6'h32};
endpackage : lat_pkg

// file: rtl/lat_pick.sv
/*
 picks one entry from one of two band tables, clamping out-of-range bands.
 assumes: band code from lat_pkg; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module lat_pick
   import lat_pkg::*;
#(
   parameter lat_pkg::tab_t TAB0 = lat_pkg::RD_NODBI,
   parameter lat_pkg::tab_t TAB1 = lat_pkg::RD_DBI
) (
   input  wire logic          sel,
   input  wire lat_pkg::band_t band,
   output var   lat_pkg::lat_t val
);
   always_comb begin
      if (band > BAND_TOP) begin
         val = sel ? TAB1[BAND_TOP] : TAB0[BAND_TOP];
      end else begin
         val = sel ? TAB1[band] : TAB0[band];
      end
   end
endmodule : lat_pick
`default_nettype wire

// file: rtl/dram_latency_odt_timing.sv
/*
 latency and termination timing selection for one low-power dram channel.
 assumes: controller supplies band, mode bits and burst length synchronously to mclk;
 controller keeps clock inside the programmed band and reprograms before moving band.
*/
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - read delay uses no-inversion column 6..32 per band without read inversion.
// - read delay uses inversion column 6..36 per band with read inversion.
// - write set bit 0 selects set A, 1 selects set B.
// - write delay per band from set A or set B table; set B at 800 MHz from WL_B_BAND2.
// - write auto-precharge waits write recovery cycles 6..34 before internal precharge.
// - read auto-precharge waits read-to-precharge cycles 8..14 before internal precharge.
// - 32-beat bursts add 8 clocks to read-to-precharge count.
// - termination enabled when field msb set; resistance follows field value.
// - termination disabled whenever field msb is zero.
// - termination on latency per band and set, unavailable in low bands.
// - termination off latency per band and set, plus 8 for 32-beat bursts.
// - non-target termination disabled only when bits 7 and 3 both zero.
// - read termination latencies apply from 1066 MHz, with inversion variants.
// - read termination off latency gets 8 added for 32-beat bursts.
// - read termination off values assume 1.5 clock postamble fixed.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module dram_latency_odt_timing
   import lat_pkg::*;
#(
   parameter lat_pkg::lat_t WL_B_BAND2 = lat_pkg::WL_B_BAND2_DEFAULT
) (
   input  wire logic           mclk,
   input  wire logic           arst_n,
   input  wire lat_pkg::band_t band,
   input  wire logic           read_inv_en,
   input  wire logic           write_set_b,
   input  wire logic           burst32,
   input  wire logic [7:0]     termination_config_reg,
   input  wire logic           write_ap_start,
   input  wire logic           read_ap_start,
   output var   lat_pkg::lat_t read_delay_cycles,
   output var   lat_pkg::lat_t write_delay_cycles,
   output var   lat_pkg::lat_t write_recovery_cycles,
   output var   lat_pkg::lat_t read_to_precharge_cycles,
   output var   lat_pkg::lat_t term_on_latency,
   output var   lat_pkg::lat_t term_off_latency,
   output var   lat_pkg::lat_t read_term_on_latency,
   output var   lat_pkg::lat_t read_term_off_latency,
   output logic                term_valid,
   output logic                read_term_valid,
   output logic                term_en,
   output logic [3:0]          term_resistance,
   output logic                nt_term_en,
   output logic                precharge_pulse,
   output logic                precharge_busy
);
   import lat_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // table lookups
   lat_t rd_v, wr_v, wrec_v, rtp_v, ton_v, toff_v, rton_v, rtoff_v;
   lat_t nxt_wr;

   lat_pick #(.TAB0(RD_NODBI), .TAB1(RD_DBI)) u_rd (
      .sel  (read_inv_en),
      .band (band),
      .val  (rd_v)
   );
   lat_pick #(.TAB0(WR_SET_A), .TAB1(WR_SET_B)) u_wr (
      .sel  (write_set_b),
      .band (band),
      .val  (wr_v)
   );
   lat_pick #(.TAB0(WREC), .TAB1(WREC)) u_wrec (
      .sel  (1'b0),
      .band (band),
      .val  (wrec_v)
   );
   lat_pick #(.TAB0(RTP), .TAB1(RTP)) u_rtp (
      .sel  (1'b0),
      .band (band),
      .val  (rtp_v)
   );
   lat_pick #(.TAB0(TON_A), .TAB1(TON_B)) u_ton (
      .sel  (write_set_b),
      .band (band),
      .val  (ton_v)
   );
   lat_pick #(.TAB0(TOFF_A), .TAB1(TOFF_B)) u_toff (
      .sel  (write_set_b),
      .band (band),
      .val  (toff_v)
   );
   lat_pick #(.TAB0(RTON_N), .TAB1(RTON_D)) u_rton (
      .sel  (read_inv_en),
      .band (band),
      .val  (rton_v)
   );
   lat_pick #(.TAB0(RTOFF_N), .TAB1(RTOFF_D)) u_rtoff (
      .sel  (read_inv_en),
      .band (band),
      .val  (rtoff_v)
   );

   always_comb begin
      nxt_wr = wr_v;
      if (write_set_b && band == BAND_800) begin
         nxt_wr = WL_B_BAND2;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // 32-beat extension, the not-available code stays untouched
   function automatic lat_t burst_ext(input lat_t base, input logic long_burst);
      lat_t res;
      res = base;
      if (long_burst && (base != LAT_NA)) begin
         res = base + BL32_EXTRA;
      end
      return res;
   endfunction : burst_ext

   // output registers
   lat_t              read_delay_ff;
   lat_t              write_delay_ff;
   lat_t              wr_recovery_ff;
   lat_t              rd_to_pre_ff;
   lat_t              term_on_ff;
   lat_t              term_off_ff;
   lat_t              rd_term_on_ff;
   lat_t              rd_term_off_ff;
   logic              term_valid_ff;
   logic              rd_term_valid_ff;
   logic              term_en_ff;
   logic [TERM_W-1:0] term_res_ff;
   logic              nt_term_en_ff;
   logic              pulse_ff;
   logic              busy_ff;

   assign read_delay_cycles        = read_delay_ff;
   assign write_delay_cycles       = write_delay_ff;
   assign write_recovery_cycles    = wr_recovery_ff;
   assign read_to_precharge_cycles = rd_to_pre_ff;
   assign term_on_latency          = term_on_ff;
   assign term_off_latency         = term_off_ff;
   assign read_term_on_latency     = rd_term_on_ff;
   assign read_term_off_latency    = rd_term_off_ff;
   assign term_valid               = term_valid_ff;
   assign read_term_valid          = rd_term_valid_ff;
   assign term_en                  = term_en_ff;
   assign term_resistance          = term_res_ff;
   assign nt_term_en               = nt_term_en_ff;
   assign precharge_pulse          = pulse_ff;
   assign precharge_busy           = busy_ff;

   //////////////////////////////////////////////////////////////////////////
   // registered latency outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         read_delay_ff <= LAT_NA;
      end else begin
         read_delay_ff <= rd_v;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         write_delay_ff <= LAT_NA;
      end else begin
         write_delay_ff <= nxt_wr;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_recovery_ff <= LAT_NA;
      end else begin
         wr_recovery_ff <= wrec_v;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_to_pre_ff <= LAT_NA;
      end else begin
         rd_to_pre_ff <= burst_ext(rtp_v, burst32);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // registered termination latencies
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         term_on_ff <= LAT_NA;
      end else begin
         term_on_ff <= ton_v;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         term_valid_ff <= 1'b0;
      end else begin
         term_valid_ff <= (ton_v != LAT_NA);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         term_off_ff <= LAT_NA;
      end else begin
         term_off_ff <= burst_ext(toff_v, burst32);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_term_on_ff <= LAT_NA;
      end else begin
         rd_term_on_ff <= rton_v;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_term_valid_ff <= 1'b0;
      end else begin
         rd_term_valid_ff <= (rton_v != LAT_NA);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_term_off_ff <= LAT_NA;
      end else begin
         rd_term_off_ff <= burst_ext(rtoff_v, burst32);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // termination enables
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         term_en_ff <= 1'b0;
      end else begin
         term_en_ff <= termination_config_reg[TERM_MSB]
                       && (termination_config_reg[TERM_W-1:0] != TERM_OFF);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         term_res_ff <= TERM_OFF;
      end else begin
         term_res_ff <= termination_config_reg[TERM_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nt_term_en_ff <= 1'b0;
      end else begin
         nt_term_en_ff <= termination_config_reg[NT_HI_BIT]
                          | termination_config_reg[TERM_MSB];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // auto-precharge timer
   lat_t cnt_ff;
   lat_t nxt_cnt;
   logic nxt_pulse;

   always_comb begin
      nxt_cnt   = cnt_ff;
      nxt_pulse = 1'b0;
      if (write_ap_start) begin
         nxt_cnt = wrec_v;
      end else if (read_ap_start) begin
         nxt_cnt = burst_ext(rtp_v, burst32);
      end else if (cnt_ff != LAT_NA) begin
         nxt_cnt = cnt_ff - 6'h01;
         nxt_pulse = (cnt_ff == 6'h01);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= LAT_NA;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_cnt != LAT_NA);
      end
   end
endmodule : dram_latency_odt_timing
`default_nettype wire

// file: test/ap_issuer.sv
/*
 controller stand-in: one auto-precharge start pulse per request.
 assumes: req changes at falling edges of mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ap_issuer (
   input  wire logic       mclk,
   input  wire logic [1:0] req,
   output logic            write_ap_start,
   output logic            read_ap_start
);
   initial {write_ap_start, read_ap_start} = 2'h0;
   // starts only after band and mode are set
   always @(negedge mclk) begin
      write_ap_start <= req[0];
      read_ap_start  <= req[1];
   end
endmodule : ap_issuer
`default_nettype wire

// file: test/lat_timing_monitor.sv
/*
 checker for latency selection, termination decode and precharge timers.
 assumes: bound to dram_latency_odt_timing, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module lat_timing_monitor (
   input wire logic           mclk,
   input wire logic           arst_n,
   input wire lat_pkg::band_t band,
   input wire logic           read_inv_en,
   input wire logic           write_set_b,
   input wire logic           burst32,
   input wire logic [7:0]     termination_config_reg,
   input wire logic           write_ap_start,
   input wire logic           read_ap_start,
   input wire lat_pkg::lat_t  read_delay_cycles,
   input wire lat_pkg::lat_t  write_delay_cycles,
   input wire lat_pkg::lat_t  read_to_precharge_cycles,
   input wire logic           term_en,
   input wire logic [3:0]     term_resistance,
   input wire logic           nt_term_en,
   input wire logic           precharge_pulse,
   input wire logic           precharge_busy
);
   import lat_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////
   a_wr_recovery: assert property (write_ap_start && band == 3'h0 && $stable(band)
      ##1 !(write_ap_start || read_ap_start) [*6] |=> precharge_pulse) else $error("wr ap late");
   a_rd_precharge: assert property (read_ap_start && !write_ap_start && band == 3'h0
      && $stable(band) && !burst32 ##1 !(write_ap_start || read_ap_start) [*8]
      |=> precharge_pulse) else $error("rd ap late");
   a_busy_ends: assert property ($fell(precharge_busy) |-> precharge_pulse)
      else $error("busy end without pulse");
   a_term_enable: assert property ($past(arst_n) |->
      term_en == $past(termination_config_reg[3])) else $error("term enable");
   a_term_value: assert property ($past(arst_n) |->
      term_resistance == $past(termination_config_reg[3:0])) else $error("term value");
   a_nt_term: assert property ($past(arst_n) |-> nt_term_en ==
      ($past(termination_config_reg[7]) | $past(termination_config_reg[3]))) else $error("nt");
   a_rd_top: assert property ($past(arst_n) && $past(band) == 3'h6 |->
      read_delay_cycles == ($past(read_inv_en) ? 6'h24 : 6'h20)) else $error("rd top");
   a_wr_top: assert property ($past(arst_n) && $past(band) == 3'h6 |->
      write_delay_cycles == ($past(write_set_b) ? 6'h1E : 6'h10)) else $error("wr top");
   a_rtp_top: assert property ($past(arst_n) && $past(band) == 3'h6 |->
      read_to_precharge_cycles == ($past(burst32) ? 6'h16 : 6'h0E)) else $error("rtp top");
endmodule : lat_timing_monitor
bind dram_latency_odt_timing lat_timing_monitor mon (.mclk, .arst_n, .band, .read_inv_en,
   .write_set_b, .burst32, .termination_config_reg, .write_ap_start, .read_ap_start,
   .read_delay_cycles, .write_delay_cycles, .read_to_precharge_cycles, .term_en,
   .term_resistance, .nt_term_en, .precharge_pulse, .precharge_busy);
`default_nettype wire

// file: test/dram_latency_odt_timing_tb_top.sv
/*
 self-checking bench: latency tables, termination decode, precharge timers.
 assumes: lat_pkg compiled first; ap_issuer plays the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module dram_latency_odt_timing_tb_top;
   import lat_pkg::*;
   logic mclk = 1'b0, arst_n = 1'b0, read_inv_en = 1'b0, write_set_b = 1'b0, burst32 = 1'b0;
   band_t band = 3'h0;
   logic [7:0] termination_config_reg = 8'h00;
   logic [1:0] req = 2'h0;
   logic write_ap_start, read_ap_start, term_valid, read_term_valid, term_en, nt_term_en;
   logic precharge_pulse, precharge_busy;
   logic [3:0] term_resistance;
   lat_t read_delay_cycles, write_delay_cycles, write_recovery_cycles, read_to_precharge_cycles;
   lat_t term_on_latency, term_off_latency, read_term_on_latency, read_term_off_latency;
   int miscompares = 0, comparisons = 0;
   int rdn[7] = '{6, 10, 14, 20, 24, 28, 32}, rdd[7] = '{6, 12, 16, 22, 28, 32, 36};
   int wa[7] = '{4, 6, 8, 10, 12, 14, 16}, wb[7] = '{4, 8, 12, 18, 22, 26, 30};
   int wr[7] = '{6, 10, 16, 20, 24, 30, 34}, rp[7] = '{8, 8, 8, 8, 10, 12, 14};
   int ta[7] = '{0, 0, 0, 4, 4, 6, 6}, tob[7] = '{0, 0, 6, 12, 14, 18, 20};
   int fa[7] = '{0, 0, 0, 20, 22, 24, 26}, fb[7] = '{0, 0, 22, 28, 32, 36, 40};
   int rn[7] = '{0, 0, 0, 14, 18, 22, 26}, rd[7] = '{0, 0, 0, 16, 22, 26, 30};
   int on[7] = '{0, 0, 0, 32, 36, 42, 46}, od[7] = '{0, 0, 0, 34, 40, 46, 50};
   dram_latency_odt_timing dut (.mclk, .arst_n, .band, .read_inv_en, .write_set_b, .burst32,
      .termination_config_reg, .write_ap_start, .read_ap_start, .read_delay_cycles,
      .write_delay_cycles, .write_recovery_cycles, .read_to_precharge_cycles, .term_on_latency,
      .term_off_latency, .read_term_on_latency, .read_term_off_latency, .term_valid,
      .read_term_valid, .term_en, .term_resistance, .nt_term_en, .precharge_pulse,
      .precharge_busy);
   ap_issuer ctrl (.mclk, .req, .write_ap_start, .read_ap_start);
   initial forever #20 mclk = ~mclk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   task automatic t_lat;
      int e;
      int b;
      for (int k = 0; k < 8; k++) for (int m = 0; m < 8; m++) begin
         @(negedge mclk);
         b = (k > 6) ? 6 : k;
         band = k[2:0];
         {read_inv_en, write_set_b, burst32} = m[2:0];
         @(negedge mclk);
         chk(read_delay_cycles, m[2] ? rdd[b] : rdn[b]);
         chk(write_delay_cycles, m[1] ? wb[b] : wa[b]);
         chk(write_recovery_cycles, wr[b]);
         chk(read_to_precharge_cycles, rp[b] + 8 * m[0]);
         e = m[1] ? tob[b] : ta[b];
         chk(term_on_latency, e);
         chk(term_valid, e != 0);
         e = m[1] ? fb[b] : fa[b];
         chk(term_off_latency, e + (e != 0 ? 8 * m[0] : 0));
         chk(read_term_on_latency, m[2] ? rd[b] : rn[b]);
         chk(read_term_valid, b > 2);
         e = m[2] ? od[b] : on[b];
         chk(read_term_off_latency, e + (e != 0 ? 8 * m[0] : 0));
      end
   endtask : t_lat
   task automatic t_term;
      for (int v = 0; v < 256; v++) begin
         @(negedge mclk);
         termination_config_reg = v[7:0];
         @(negedge mclk);
         chk(term_en, v[3]);
         chk(term_resistance, v[3:0]);
         chk(nt_term_en, v[7] | v[3]);
      end
   endtask : t_term
   task automatic t_ap(input int b, input logic rdx, input logic l32, input int n);
      int c;
      @(negedge mclk);
      band = b[2:0];
      burst32 = l32;
      req <= {rdx, !rdx};
      @(negedge mclk);
      req <= 2'h0;
      c = 0;
      do begin
         @(negedge mclk);
         c++;
         if (c == 1) chk(precharge_busy, 1'b1);
      end while (precharge_pulse !== 1'b1 && c < 60);
      if (c == 60) begin
         miscompares++;
         test_done();
      end
      chk(c, n + 1);
      chk(precharge_busy, 1'b0);
   endtask : t_ap
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      arst_n = 1'b1;
      t_lat();
      t_term();
      for (int b = 0; b < 7; b++) begin
         t_ap(b, 1'b0, 1'b0, wr[b]);
         t_ap(b, 1'b1, 1'b0, rp[b]);
         t_ap(b, 1'b1, 1'b1, rp[b] + 8);
      end
      test_done();
   end
endmodule : dram_latency_odt_timing_tb_top
`default_nettype wire
